// [core/cif_pkg.sv]
package cif_pkg;

  // Data path widths
  localparam int CIF_DATA_W = 16;
  localparam int CIF_ADDR_W = 12;
  localparam int CIF_IPL_W = 3;
  localparam int CIF_BANK_REGS = 7;
  localparam int CIF_IDX_W = 3;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [11:0] CIF_ADDR_FLAG = 12'h000;
  localparam logic [11:0] CIF_ADDR_ISP = 12'h004;
  localparam logic [11:0] CIF_ADDR_USP = 12'h008;
  localparam logic [11:0] CIF_ADDR_ASP = 12'h00C;
  localparam logic [11:0] CIF_ADDR_STAT = 12'h010;
  localparam logic [11:0] CIF_ADDR_BANK = 12'h020;
  localparam logic [11:0] CIF_ADDR_BANK_END = 12'h03C;

  // Flag register field positions
  localparam int CIF_FLG_BANK_BIT = 4;
  localparam int CIF_FLG_GATE_BIT = 6;
  localparam int CIF_FLG_SEL_BIT = 7;
  localparam int CIF_FLG_IPL_LSB = 12;
  localparam int CIF_FLG_RSVD_BIT = 15;

  // Status register field positions
  localparam int CIF_STAT_REQ_BIT = 0;
  localparam int CIF_STAT_LVL_LSB = 1;
  localparam int CIF_STAT_ACK_BIT = 4;

  // Highest trap vector that forces the interrupt stack
  localparam logic [5:0] CIF_TRAP_SEL_MAX = 6'h1F;

  // Reset values
  localparam logic [15:0] CIF_SP_RST = 16'h0000;
  localparam logic [2:0] CIF_IPL_RST = 3'h0;

  typedef struct packed {
    logic gate;
    logic stackSel;
    logic [CIF_IPL_W-1:0] processor_priority_level;
    logic bankSel;
    logic [CIF_DATA_W-1:0] interrupt_stack_pointer;
    logic [CIF_DATA_W-1:0] user_stack_pointer;
    logic [CIF_DATA_W-1:0] activeSp;
    logic irqAck;
    logic [CIF_IPL_W-1:0] ackLevel;
    logic wrPend;
    logic [CIF_ADDR_W-1:0] wrAddr;
    logic [31:0] rdata;
    logic readyOut;
    logic resp;
  } cif_state_s;

  localparam cif_state_s CIF_STATE_RST = '{
    gate: 1'b0, stackSel: 1'b0, processor_priority_level: CIF_IPL_RST, bankSel: 1'b0,
    interrupt_stack_pointer: CIF_SP_RST, user_stack_pointer: CIF_SP_RST, activeSp: CIF_SP_RST,
    irqAck: 1'b0, ackLevel: CIF_IPL_RST, wrPend: 1'b0, wrAddr: 12'h000,
    rdata: 32'h00000000, readyOut: 1'b1, resp: 1'b0
  };

endpackage : cif_pkg

// [core/cif_bank_file.sv]
`timescale 1ns/10ps
module cif_bank_file #(
  parameter int WIDTH = 16,
  parameter int COUNT = 7
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Write port
  input wire logic wrEn,
  input wire logic wrBank,
  input wire logic [2:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  // Read port
  input wire logic rdBank,
  input wire logic [2:0] rdIdx,
  output logic [WIDTH-1:0] rdData
);

  // Two copies of data, address and frame base registers
  logic [WIDTH-1:0] mem_reg [2][COUNT];

  // Index past the bank reads zero rather than wrapping
  always_comb begin
    rdData = '0;
    if (int'(rdIdx) < COUNT) begin
      rdData = mem_reg[rdBank][rdIdx];
    end
  end

  // Write only the addressed copy
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int b = 0; b < 2; b++) begin
        for (int i = 0; i < COUNT; i++) begin
          mem_reg[b][i] <= '0;
        end
      end
    end else if (wrEn && int'(wrIdx) < COUNT) begin
      mem_reg[wrBank][wrIdx] <= wrData;
    end
  end

endmodule : cif_bank_file

// [core/cif_flag_unit.sv]
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
// How it works
// - Gate flag 0 blocks every maskable request; 1 lets requests be weighed.
// - Any acknowledged request, hardware or trap, clears the gate flag.
// - Stack select 0 picks the interrupt stack pointer, 1 the user one.
// - Hardware acknowledge or trap with vector 0..31 clears stack select.
// - Processor priority level is a 3-bit field, levels 0 to 7.
// - Request accepted only if its level is strictly above the priority level.
// - Reserved flag bit: software writes 0, reads give no defined value.
// - Data, address and frame base registers exist in two selectable banks.
module cif_flag_unit (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Interrupt requesters
  input wire logic irqReq,
  input wire logic [cif_pkg::CIF_IPL_W-1:0] irqLevel,
  output logic irqAck,
  output logic [cif_pkg::CIF_IPL_W-1:0] ackLevel,
  // Instruction sequencer
  input wire logic trapExec,
  input wire logic [5:0] trapVector,
  output logic intGate,
  output logic stackSelect,
  output logic [cif_pkg::CIF_IPL_W-1:0] processorPriorityLevel,
  output logic bankSelect,
  output logic [cif_pkg::CIF_DATA_W-1:0] activeStackPtr
);
  import cif_pkg::*;

  // Register map, byte offsets in the low 12 address bits:
  //   flag word: bank select, gate, stack select, priority, reserved top bit
  //   interrupt stack pointer, user stack pointer, then an alias of the active one
  //   status, read only: pending request, its level, would it be taken now
  //   bank window: seven words of the selected copy, index taken from the offset
  // Only the low half of each word carries data; the upper half reads zero.
  // Unmapped offsets read zero and drop writes, always with an OKAY response.

  // Whole block state, registered in one place
  cif_state_s s_reg;
  cif_state_s s_next;
  // Decode and request weighing
  logic addrPhase;
  logic accept;
  // Bank file write and read ports
  logic bankWe;
  logic [CIF_IDX_W-1:0] bankWrIdx;
  logic [CIF_IDX_W-1:0] bankRdIdx;
  logic [CIF_DATA_W-1:0] bankRdData;

  // Bank window decode, shared by read and write paths
  function automatic logic cif_bank_hit(input logic [CIF_ADDR_W-1:0] a);
    cif_bank_hit = (a >= CIF_ADDR_BANK) && (a < CIF_ADDR_BANK_END) && (a[1:0] == 2'b00);
  endfunction : cif_bank_hit

  // Word index inside the bank window
  function automatic logic [CIF_IDX_W-1:0] cif_bank_idx(input logic [CIF_ADDR_W-1:0] a);
    logic [CIF_ADDR_W-1:0] off;
    off = a - CIF_ADDR_BANK;
    cif_bank_idx = off[CIF_IDX_W+1:2];
  endfunction : cif_bank_idx

  // Gate open and level strictly above the current priority
  function automatic logic cif_accept(input logic req, input logic gate,
                                      input logic [CIF_IPL_W-1:0] lvl, input logic [CIF_IPL_W-1:0] processor_priority_level);
    cif_accept = req && gate && (lvl > processor_priority_level);
  endfunction : cif_accept

  // Transfer taken only while the bus is ready; hreadyout stays high, so
  // every address phase completes in one cycle and no data phase stalls.
  // Requests are weighed against the registered flags, not those being written.
  assign addrPhase = hsel && htrans[1] && hready;
  assign accept = cif_accept(irqReq, s_reg.gate, irqLevel, s_reg.processor_priority_level);
  assign bankWe = s_reg.wrPend && cif_bank_hit(s_reg.wrAddr);
  assign bankWrIdx = cif_bank_idx(s_reg.wrAddr);
  assign bankRdIdx = cif_bank_idx(haddr[CIF_ADDR_W-1:0]);

  // Banked general, address and frame base registers
  // Both ports follow the live bank select, so a switch takes effect at once
  cif_bank_file #(
    .WIDTH(CIF_DATA_W),
    .COUNT(CIF_BANK_REGS)
  ) u_bank (
    .mclk(mclk),
    .reset_n(reset_n),
    .wrEn(bankWe),
    .wrBank(s_reg.bankSel),
    .wrIdx(bankWrIdx),
    .wrData(hwdata[CIF_DATA_W-1:0]),
    .rdBank(s_reg.bankSel),
    .rdIdx(bankRdIdx),
    .rdData(bankRdData)
  );

  // Next state: bus first, then hardware events so they win over writes
  always_comb begin
    // Every field keeps its value unless a path below changes it
    s_next = s_reg;
    // Pulses and bus handshake fall back each cycle
    s_next.irqAck = 1'b0;
    s_next.wrPend = 1'b0;
    s_next.readyOut = 1'b1;
    s_next.resp = 1'b0;
    // Data phase of a write; unmapped offsets are dropped silently
    if (s_reg.wrPend) begin
      unique case (s_reg.wrAddr)
        CIF_ADDR_FLAG: begin
          // Reserved top bit is not stored
          s_next.bankSel = hwdata[CIF_FLG_BANK_BIT];
          s_next.gate = hwdata[CIF_FLG_GATE_BIT];
          s_next.stackSel = hwdata[CIF_FLG_SEL_BIT];
          s_next.processor_priority_level = hwdata[CIF_FLG_IPL_LSB +: CIF_IPL_W];
        end
        CIF_ADDR_ISP: s_next.interrupt_stack_pointer = hwdata[CIF_DATA_W-1:0];
        CIF_ADDR_USP: s_next.user_stack_pointer = hwdata[CIF_DATA_W-1:0];
        // Alias follows the stack select as it stands before this edge
        CIF_ADDR_ASP: begin
          if (s_reg.stackSel) begin
            s_next.user_stack_pointer = hwdata[CIF_DATA_W-1:0];
          end else begin
            s_next.interrupt_stack_pointer = hwdata[CIF_DATA_W-1:0];
          end
        end
        // Bank window writes go through the bank file instead
        default: ;
      endcase
    end
    // Address phase: latch writes, sample read data now
    // Capturing read data here keeps hrdata a flop; the price is that a read
    // issued right behind a write to the same word still sees the old value.
    if (addrPhase) begin
      if (hwrite) begin
        s_next.wrPend = 1'b1;
        s_next.wrAddr = haddr[CIF_ADDR_W-1:0];
      end else begin
        s_next.rdata = 32'h00000000;
        // Bank read port already shows the word for this offset
        if (cif_bank_hit(haddr[CIF_ADDR_W-1:0])) begin
          s_next.rdata[CIF_DATA_W-1:0] = bankRdData;
        end else begin
          unique case (haddr[CIF_ADDR_W-1:0])
            CIF_ADDR_FLAG: begin
              // Reserved bit simply reads 0, callers must not rely on it
              s_next.rdata[CIF_FLG_RSVD_BIT] = 1'b0;
              s_next.rdata[CIF_FLG_BANK_BIT] = s_reg.bankSel;
              s_next.rdata[CIF_FLG_GATE_BIT] = s_reg.gate;
              s_next.rdata[CIF_FLG_SEL_BIT] = s_reg.stackSel;
              s_next.rdata[CIF_FLG_IPL_LSB +: CIF_IPL_W] = s_reg.processor_priority_level;
            end
            CIF_ADDR_ISP: s_next.rdata[CIF_DATA_W-1:0] = s_reg.interrupt_stack_pointer;
            CIF_ADDR_USP: s_next.rdata[CIF_DATA_W-1:0] = s_reg.user_stack_pointer;
            CIF_ADDR_ASP: s_next.rdata[CIF_DATA_W-1:0] = s_reg.activeSp;
            // Live view of the requester, not a latched copy
            CIF_ADDR_STAT: begin
              s_next.rdata[CIF_STAT_REQ_BIT] = irqReq;
              s_next.rdata[CIF_STAT_LVL_LSB +: CIF_IPL_W] = irqLevel;
              s_next.rdata[CIF_STAT_ACK_BIT] = accept;
            end
            default: ;
          endcase
        end
      end
    end
    // Software trap taken by the sequencer
    // Traps count as taken requests, so the gate closes whatever the vector
    // Vectors above the boundary keep the current stack: select left alone
    if (trapExec) begin
      s_next.gate = 1'b0;
      if (trapVector <= CIF_TRAP_SEL_MAX) begin
        s_next.stackSel = 1'b0;
      end
    end
    // Hardware acknowledge; raises priority to the accepted level
    // Applied last so an event beats a flag write landing on the same edge
    // Strict compare: a request at the level in service keeps waiting
    if (accept) begin
      s_next.gate = 1'b0;
      s_next.stackSel = 1'b0;
      s_next.processor_priority_level = irqLevel;
      s_next.irqAck = 1'b1;
      s_next.ackLevel = irqLevel;
    end
    // Registered copy of the selected pointer
    // Built from next values so the alias never lags a select change
    s_next.activeSp = s_next.stackSel ? s_next.user_stack_pointer : s_next.interrupt_stack_pointer;
  end

  // Single state register
  // Reset loads constants only; the bank file clears its own words
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= CIF_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  // No logic between flop and port, so the sequencer sees clean timing
  assign hreadyout = s_reg.readyOut;
  assign hrdata = s_reg.rdata;
  assign hresp = s_reg.resp;
  assign irqAck = s_reg.irqAck;
  assign ackLevel = s_reg.ackLevel;
  assign intGate = s_reg.gate;
  assign stackSelect = s_reg.stackSel;
  assign processorPriorityLevel = s_reg.processor_priority_level;
  assign bankSelect = s_reg.bankSel;
  assign activeStackPtr = s_reg.activeSp;

endmodule : cif_flag_unit

// [test/cif_flag_unit_sva.sv]
`timescale 1ns/10ps
module cif_flag_unit_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Bus address phase
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  // Requests and traps
  input wire logic irqReq,
  input wire logic [cif_pkg::CIF_IPL_W-1:0] irqLevel,
  input wire logic irqAck,
  input wire logic [cif_pkg::CIF_IPL_W-1:0] ackLevel,
  input wire logic trapExec,
  input wire logic [5:0] trapVector,
  // Flags
  input wire logic intGate,
  input wire logic stackSelect,
  input wire logic [cif_pkg::CIF_IPL_W-1:0] processorPriorityLevel
);
  logic wrPhase;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Write data phase: a flag write may land at its end edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wrPhase <= 1'b0;
    end else begin
      wrPhase <= hsel && htrans[1] && hwrite && hready;
    end
  end
  a_gate_blocks: assert property (irqAck |-> $past(intGate)) else $error("ack with gate closed");
  a_gate_accepts: assert property (
    irqReq && intGate && irqLevel > processorPriorityLevel && !trapExec && !wrPhase |=> irqAck)
    else $error("eligible request not taken");
  a_ack_closes: assert property (irqAck |-> !intGate && !stackSelect) else $error("ack left flags");
  a_trap_gate: assert property (trapExec |=> !intGate) else $error("trap left gate open");
  a_trap_low: assert property (trapExec && trapVector <= 6'h1F |=> !stackSelect) else $error("low trap sel");
  a_trap_high: assert property (
    trapExec && trapVector > 6'h1F && !wrPhase && !(irqReq && intGate) |=> $stable(stackSelect))
    else $error("high trap moved sel");
  a_prio_strict: assert property (
    irqAck |-> $past(irqLevel) > $past(processorPriorityLevel))
    else $error("level not above priority");
  a_ack_level: assert property (
    irqAck |-> ackLevel == $past(irqLevel) && processorPriorityLevel == ackLevel)
    else $error("ack level wrong");
endmodule : cif_flag_unit_sva

bind cif_flag_unit cif_flag_unit_sva chk (.*);

// [test/cif_irq_model.sv]
`timescale 1ns/10ps
module cif_irq_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Bench command
  input wire logic raise,
  input wire logic [2:0] lvl,
  // Device side
  input wire logic irqAck,
  output logic irqReq,
  output logic [2:0] irqLevel
);
  // Request stays pending until taken; released level shows its inverse
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irqReq <= 1'b0;
      irqLevel <= 3'h0;
    end else if (raise) begin
      irqReq <= 1'b1;
      irqLevel <= lvl;
    end else if (irqAck) begin
      irqReq <= 1'b0;
      irqLevel <= ~irqLevel;
    end
  end
endmodule : cif_irq_model

// [test/cif_flag_unit_test.sv]
`timescale 1ns/10ps
module cif_flag_unit_test;
  import cif_pkg::*;
  logic mclk, reset_n, hsel, hwrite, hreadyout, hresp, irqReq, irqAck, trapExec, intGate, stackSelect;
  logic bankSelect, raise;
  logic [1:0] htrans;
  logic [2:0] irqLevel, ackLevel, ppl, lvl;
  logic [5:0] trapVector;
  logic [15:0] asp;
  logic [31:0] haddr, hwdata, hrdata, q;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int nAck = 0;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  cif_flag_unit dut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .irqReq(irqReq), .irqLevel(irqLevel), .irqAck(irqAck),
    .ackLevel(ackLevel), .trapExec(trapExec), .trapVector(trapVector), .intGate(intGate),
    .stackSelect(stackSelect), .processorPriorityLevel(ppl), .bankSelect(bankSelect), .activeStackPtr(asp));
  cif_irq_model src (.mclk(mclk), .reset_n(reset_n), .raise(raise), .lvl(lvl), .irqAck(irqAck),
    .irqReq(irqReq), .irqLevel(irqLevel));
  // Hang guard and acknowledge counter
  always @(posedge mclk) begin
    cyc++;
    if (irqAck === 1'b1) nAck++;
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // One single transfer; two idle edges let a write reach the outputs
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h00000, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
    repeat (2) @(posedge mclk);
  endtask : bus
  task automatic trap(input logic [5:0] v);
    @(posedge mclk);
    trapExec <= 1'b1;
    trapVector <= v;
    @(posedge mclk);
    trapExec <= 1'b0;
    trapVector <= ~v;
    repeat (2) @(posedge mclk);
  endtask : trap
  task complete_run;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    {reset_n, hsel, hwrite, htrans, haddr, hwdata, trapExec, trapVector, raise, lvl} <= '0;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    bus(1'b0, CIF_ADDR_FLAG, 32'h0);
    chk(q & 32'h7FFF, 32'h0, "flag reset");
    bus(1'b1, CIF_ADDR_ISP, 32'h1234);
    bus(1'b1, CIF_ADDR_USP, 32'h5678);
    chk(32'(asp), 32'h1234, "isp active");
    bus(1'b1, CIF_ADDR_FLAG, 32'h0080);
    chk(32'(asp), 32'h5678, "usp active");
    // Alias write must land in the user pointer while that one is selected
    bus(1'b1, CIF_ADDR_ASP, 32'h9ABC);
    bus(1'b0, CIF_ADDR_USP, 32'h0);
    chk(q, 32'h9ABC, "alias to usp");
    chk(32'(asp), 32'h9ABC, "alias active");
    // Fill both banks, then read each copy back
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 2; b++) begin
        bus(1'b1, CIF_ADDR_FLAG, b ? 32'h0010 : 32'h0000);
        chk(32'({hresp, bankSelect}), 32'(b), "bank select");
        for (int i = 0; i < CIF_BANK_REGS; i++) begin
          bus(p == 0, CIF_ADDR_BANK + 12'(4 * i), 32'(b * 256 + i));
          if (p == 1) chk(q & 32'hFFFF, 32'(b * 256 + i), "bank reg");
        end
      end
    end
    $display("test stack and banks done");
    bus(1'b1, CIF_ADDR_FLAG, 32'h7000);
    chk(32'(ppl), 32'h7, "prio max");
    @(posedge mclk);
    raise <= 1'b1;
    lvl <= 3'h5;
    @(posedge mclk);
    raise <= 1'b0;
    bus(1'b1, CIF_ADDR_FLAG, 32'h4000);
    bus(1'b0, CIF_ADDR_STAT, 32'h0);
    chk(q & 32'h1F, 32'h0B, "pending, gate shut");
    bus(1'b1, CIF_ADDR_FLAG, 32'h50C0);
    repeat (2) @(posedge mclk);
    chk(32'(nAck), 32'h0, "equal level held");
    bus(1'b1, CIF_ADDR_FLAG, 32'h40C0);
    repeat (2) @(posedge mclk);
    chk(32'(nAck), 32'h1, "one ack");
    chk(32'({ackLevel, ppl}), 32'h2D, "ack level");
    chk(32'({intGate, stackSelect}), 32'h0, "ack flags");
    chk(32'(asp), 32'h1234, "isp after ack");
    $display("test requests done");
    bus(1'b1, CIF_ADDR_FLAG, 32'h00C0);
    trap(6'h20);
    chk(32'({intGate, stackSelect}), 32'h1, "high trap");
    trap(6'h1F);
    chk(32'(stackSelect), 32'h0, "low trap");
    $display("test traps done");
    complete_run();
  end
endmodule : cif_flag_unit_test
